/* File: common/napc_pkg.sv */
package napc_pkg;

  // ==========================================
  // Packet identifiers
  localparam logic [7:0] ID_BODY_VEL  = 8'h2F;
  localparam logic [7:0] ID_HEADING   = 8'h30;
  localparam logic [7:0] ID_RUN_TIME  = 8'h31;
  localparam logic [7:0] ID_MAG_FIELD = 8'h32;
  localparam logic [7:0] ID_ODO_STATE = 8'h33;
  localparam logic [7:0] ID_EXT_TIME  = 8'h34;
  localparam logic [7:0] ID_EXT_DEPTH = 8'h35;
  localparam logic [7:0] ID_GEOID     = 8'h36;
  localparam logic [7:0] ID_RTCM      = 8'h37;

  // ==========================================
  // Payload lengths
  localparam logic [7:0] LEN_BODY_VEL_S = 8'h10;
  localparam logic [7:0] LEN_BODY_VEL_L = 8'h18;
  localparam logic [7:0] LEN_HEADING    = 8'h08;
  localparam logic [7:0] LEN_RUN_TIME   = 8'h08;
  localparam logic [7:0] LEN_MAG_FIELD  = 8'h0C;
  localparam logic [7:0] LEN_ODO_STATE  = 8'h14;
  localparam logic [7:0] LEN_EXT_TIME   = 8'h08;
  localparam logic [7:0] LEN_EXT_DEPTH  = 8'h08;
  localparam logic [7:0] LEN_GEOID      = 8'h04;
  localparam logic [7:0] LEN_RTCM_MAX   = 8'hFF;

  // ==========================================
  // Field offsets and word slots
  localparam int WORD_BYTES     = 4;
  localparam int NUM_WORDS      = 6;
  localparam int OFF_ODO_ACTIVE = 16;
  localparam int OFF_ODO_RSVD   = 17;

  // ==========================================
  // Buffer geometry
  localparam int BUF_WIDTH = 8;
  localparam int BUF_DEPTH = 2;

endpackage

/* File: verilog/napc_skid_buf.sv */
`timescale 1ns/100ps
`default_nettype none
module napc_skid_buf #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 2
) (
  // Clock and reset
  input  wire logic             clk,
  input  wire logic             sys_rst,
  // Fill side
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  // Drain side
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  initial begin
    if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin
      $error("DEPTH must be a power of two of at least 2");
    end
  end

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW:0]      wr_q;
  logic [AW:0]      rd_q;
  logic             push;
  logic             pop;

  assign in_ready  = (wr_q - rd_q) != (AW+1)'(DEPTH);
  assign out_valid = wr_q != rd_q;
  assign out_data  = mem_q[rd_q[AW-1:0]];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  // ==========================================
  // Pointers
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      wr_q <= '0;
      rd_q <= '0;
    end else begin
      if (push) begin
        wr_q <= wr_q + 1'b1;
      end
      if (pop) begin
        rd_q <= rd_q + 1'b1;
      end
    end
  end

  // ==========================================
  // Storage
  always_ff @(posedge clk) begin
    if (push) begin
      mem_q[wr_q[AW-1:0]] <= in_data;
    end
  end
endmodule
`default_nettype wire

/* File: verilog/napc_codec.sv */
// Summary of operation
// R01: ID 47 body velocity, 16 or 24 bytes
// R02: Velocity XYZ at 0,4,8; deviation at 12
// R03: Sender sets length to deviation format
// R04: ID 48 heading and deviation, 8 bytes
// R05: ID 49 running time, seconds and microseconds
// R06: ID 50 magnetic field XYZ, 12 bytes
// R07: ID 51 odometer state, 20 bytes
// R08: ID 52 external time, 8 bytes
// R09: ID 53 depth below sea level, 8 bytes
// R10: ID 54 geoid height, 4 bytes
// R11: Geoid height is ellipsoid minus sea level
// R12: ID 55 payload passed unchanged to receiver
// R13: RTCM length up to 255 bytes
// R14: Wrong length packets are discarded; RTCM frames are forwarded without checking their byte count against the length
// R15: Little endian, IEEE single precision fields
`timescale 1ns/100ps
`default_nettype none
module napc_codec
  import napc_pkg::*;
#(
  parameter int BUF_W = napc_pkg::BUF_WIDTH,
  parameter int BUF_D = napc_pkg::BUF_DEPTH
) (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        sys_rst,
  // Received payload bytes from host link
  input  wire logic        rx_start,
  input  wire logic [7:0]  rx_id,
  input  wire logic [7:0]  rx_len,
  input  wire logic        rx_valid,
  output logic             rx_ready,
  input  wire logic [7:0]  rx_data,
  input  wire logic        rx_last,
  // Decoded words to navigation filter
  output logic             dec_valid,
  output logic [7:0]       dec_id,
  output logic [2:0]       dec_words,
  output logic [191:0]     dec_data,
  output logic             dec_drop,
  // Correction bytes to GNSS receiver
  output logic             gnss_valid,
  input  wire logic        gnss_ready,
  output logic [7:0]       gnss_data,
  output logic             gnss_last,
  // Transmit request from navigation filter
  input  wire logic        tx_req,
  input  wire logic [7:0]  tx_id,
  input  wire logic [159:0] tx_fields,
  output logic             tx_busy,
  // Encoded payload bytes to host link
  output logic             tx_valid,
  input  wire logic        tx_ready,
  output logic [7:0]       tx_data,
  output logic             tx_last,
  output logic [7:0]       tx_len
);
  import napc_pkg::*;

  initial begin
    if (BUF_W != 8) begin
      $error("BUF_W must be 8");
    end
    if (BUF_D < 2) begin
      $error("BUF_D must be at least 2");
    end
    if (NUM_WORDS * WORD_BYTES * 8 != 192) begin
      $error("Decoded slots must fill dec_data");
    end
    if (LEN_ODO_STATE * 8 > 160) begin
      $error("Odometer payload exceeds tx_fields");
    end
    if (OFF_ODO_RSVD + 3 != LEN_ODO_STATE) begin
      $error("Odometer reserved bytes must end the payload");
    end
  end

  typedef enum logic [1:0] {NAPC_IDLE, NAPC_FIELDS, NAPC_RTCM, NAPC_SKIP} napc_rx_e;

  // ==========================================
  // Length check
  function automatic logic napc_len_ok(input logic [7:0] id, input logic [7:0] len);
    case (id)
      // R01: two accepted lengths
      ID_BODY_VEL:  napc_len_ok = (len == LEN_BODY_VEL_S) || (len == LEN_BODY_VEL_L);
      // R04: heading and deviation words
      ID_HEADING:   napc_len_ok = len == LEN_HEADING;
      ID_RUN_TIME:  napc_len_ok = len == LEN_RUN_TIME;
      ID_MAG_FIELD: napc_len_ok = len == LEN_MAG_FIELD;
      ID_ODO_STATE: napc_len_ok = len == LEN_ODO_STATE;
      // R08: external time two words
      ID_EXT_TIME:  napc_len_ok = len == LEN_EXT_TIME;
      // R09: depth and deviation words
      ID_EXT_DEPTH: napc_len_ok = len == LEN_EXT_DEPTH;
      ID_GEOID:     napc_len_ok = len == LEN_GEOID;
      // R13: any nonzero length to limit
      ID_RTCM:      napc_len_ok = (len != 8'h00) && (len <= LEN_RTCM_MAX);
      default:      napc_len_ok = 1'b0;
    endcase
  endfunction

  napc_rx_e     rx_st_q;
  logic [7:0]   rx_cnt_q;
  logic [7:0]   rx_len_q;
  logic [7:0]   rx_id_q;
  logic [191:0] rx_acc_q;
  logic         buf_in_ready;
  logic         rx_take;
  logic         rx_hdr;
  logic         rx_empty;
  logic         rx_end;
  logic         rx_fit;

  // ==========================================
  // Receive state
  assign rx_take  = rx_valid && rx_ready;
  assign rx_ready = (rx_st_q == NAPC_RTCM) ? buf_in_ready : (rx_st_q != NAPC_IDLE);
  assign rx_hdr   = (rx_st_q == NAPC_IDLE) && rx_start;
  assign rx_empty = rx_hdr && (rx_len == 8'h00);
  assign rx_end   = rx_take && rx_last;
  assign rx_fit   = (rx_st_q == NAPC_FIELDS) && (rx_cnt_q + 8'h01 == rx_len_q);

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      rx_st_q <= NAPC_IDLE;
    end else begin
      case (rx_st_q)
        NAPC_IDLE: begin
          // R14: empty frame never leaves idle
          if (rx_hdr && !rx_empty) begin
            // R14: bad length skipped
            if (!napc_len_ok(rx_id, rx_len)) begin
              rx_st_q <= NAPC_SKIP;
            // R12: container passed through
            end else if (rx_id == ID_RTCM) begin
              rx_st_q <= NAPC_RTCM;
            end else begin
              rx_st_q <= NAPC_FIELDS;
            end
          end
        end
        NAPC_FIELDS, NAPC_RTCM, NAPC_SKIP: begin
          if (rx_end) begin
            rx_st_q <= NAPC_IDLE;
          end
        end
        default: rx_st_q <= NAPC_IDLE;
      endcase
    end
  end

  // ==========================================
  // Header capture
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      rx_len_q <= 8'h00;
      rx_id_q  <= 8'h00;
    end else if (rx_hdr) begin
      rx_len_q <= rx_len;
      rx_id_q  <= rx_id;
    end
  end

  // ==========================================
  // Byte count
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      rx_cnt_q <= 8'h00;
    end else if (rx_hdr) begin
      rx_cnt_q <= 8'h00;
    end else if (rx_take) begin
      rx_cnt_q <= rx_cnt_q + 8'h01;
    end
  end

  // ==========================================
  // Field assembly
  // R15: first byte is least significant
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      rx_acc_q <= '0;
    end else if (rx_hdr) begin
      rx_acc_q <= '0;
    end else if (rx_st_q == NAPC_FIELDS && rx_take && rx_cnt_q < 8'(NUM_WORDS * WORD_BYTES)) begin
      rx_acc_q[rx_cnt_q*8 +: 8] <= rx_data;
    end
  end

  // ==========================================
  // Decoded flags
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      dec_valid <= 1'b0;
      dec_drop  <= 1'b0;
    end else begin
      dec_valid <= rx_end && rx_fit;
      // R14: short, long, skipped or empty dropped
      dec_drop  <= rx_empty || (rx_end && (rx_st_q != NAPC_RTCM) && !rx_fit);
    end
  end

  // ==========================================
  // Decoded words
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      dec_id    <= 8'h00;
      dec_words <= 3'h0;
      dec_data  <= '0;
    end else if (rx_end && rx_fit) begin
      // R02: words at 0,4,8,12 and beyond
      // R03: length selects deviation form
      dec_id    <= rx_id_q;
      dec_words <= 3'(rx_len_q >> 2);
      dec_data  <= rx_acc_q;
      dec_data[rx_cnt_q*8 +: 8] <= rx_data;
    end
  end

  // R12: RTCM bytes unchanged to receiver
  napc_skid_buf #(
    .WIDTH (BUF_W + 1),
    .DEPTH (BUF_D)
  ) u_rtcm_buf (
    .clk       (clk),
    .sys_rst   (sys_rst),
    .in_valid  (rx_valid && rx_st_q == NAPC_RTCM),
    .in_ready  (buf_in_ready),
    .in_data   ({rx_last, rx_data}),
    .out_valid (gnss_valid),
    .out_ready (gnss_ready),
    .out_data  ({gnss_last, gnss_data})
  );

  // ==========================================
  // Transmit side
  logic [159:0] tx_sh_q;
  logic [7:0]   tx_rem_q;
  logic [7:0]   tx_len_sel;
  logic         tx_load;
  logic         tx_step;

  always_comb begin
    case (tx_id)
      // R05: running time 8 bytes
      ID_RUN_TIME:  tx_len_sel = LEN_RUN_TIME;
      // R06: magnetic field 12 bytes
      ID_MAG_FIELD: tx_len_sel = LEN_MAG_FIELD;
      // R07: odometer state 20 bytes
      ID_ODO_STATE: tx_len_sel = LEN_ODO_STATE;
      // R10: geoid height 4 bytes
      ID_GEOID:     tx_len_sel = LEN_GEOID;
      default:      tx_len_sel = 8'h00;
    endcase
  end

  assign tx_busy  = tx_rem_q != 8'h00;
  assign tx_valid = tx_busy;
  assign tx_data  = tx_sh_q[7:0];
  assign tx_last  = tx_rem_q == 8'h01;

  assign tx_load  = !tx_busy && tx_req && (tx_len_sel != 8'h00);
  assign tx_step  = tx_valid && tx_ready;

  // ==========================================
  // Bytes left
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      tx_rem_q <= 8'h00;
    end else if (tx_load) begin
      tx_rem_q <= tx_len_sel;
    end else if (tx_step) begin
      tx_rem_q <= tx_rem_q - 8'h01;
    end
  end

  // ==========================================
  // Frame length
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      tx_len <= 8'h00;
    end else if (tx_load) begin
      tx_len <= tx_len_sel;
    end
  end

  // ==========================================
  // Payload shifter
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      tx_sh_q <= '0;
    end else if (tx_load) begin
      // R11: geoid value passed as supplied
      tx_sh_q <= tx_fields;
      // R07: reserved bytes cleared
      if (tx_id == ID_ODO_STATE) begin
        tx_sh_q[OFF_ODO_RSVD*8 +: 24] <= 24'h00_0000;
      end
    // R15: low byte sent first
    end else if (tx_step) begin
      tx_sh_q <= tx_sh_q >> 8;
    end
  end
endmodule
`default_nettype wire

/* File: tb/napc_codec_sva.sv */
`timescale 1ns/100ps
`default_nettype none
module napc_codec_chk
  import napc_pkg::*;
(
  // Clock and reset
  input wire logic       clk,
  input wire logic       sys_rst,
  // Receive side
  input wire logic       dec_valid,
  input wire logic       dec_drop,
  input wire logic [7:0] dec_id,
  input wire logic [2:0] dec_words,
  // Correction side
  input wire logic       gnss_valid,
  input wire logic       gnss_ready,
  input wire logic [7:0] gnss_data,
  input wire logic       gnss_last,
  // Transmit side
  input wire logic       tx_req,
  input wire logic [7:0] tx_id,
  input wire logic       tx_busy,
  input wire logic       tx_valid,
  input wire logic       tx_ready,
  input wire logic [7:0] tx_data,
  input wire logic       tx_last,
  input wire logic [7:0] tx_len
);
  wire tx_go = tx_req && !tx_busy;
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  // ==========
  // Assertions
  tx_hold_a: assert property (tx_valid && !tx_ready |=>
    tx_valid && $stable({tx_data, tx_last, tx_len})) else $error("tx byte moved");
  gnss_hold_a: assert property (gnss_valid && !gnss_ready |=>
    gnss_valid && $stable({gnss_data, gnss_last})) else $error("gnss byte moved");
  geoid_len_a: assert property (tx_go && tx_id == ID_GEOID |=>
    tx_valid && tx_len == LEN_GEOID) else $error("geoid length");
  odo_len_a: assert property (tx_go && tx_id == ID_ODO_STATE |=>
    tx_len == LEN_ODO_STATE) else $error("odometer length");
  run_len_a: assert property (tx_go && tx_id == ID_RUN_TIME |=>
    tx_len == LEN_RUN_TIME) else $error("running time length");
  mag_len_a: assert property (tx_go && tx_id == ID_MAG_FIELD |=>
    tx_len == LEN_MAG_FIELD) else $error("field length");
  tx_refuse_a: assert property (tx_go && tx_id == ID_HEADING |=>
    !tx_busy) else $error("heading sent");
  vel_words_a: assert property (dec_valid && dec_id == ID_BODY_VEL |->
    dec_words == 3'h4 || dec_words == 3'h6) else $error("velocity words");
  dec_pulse_a: assert property (dec_valid |->
    !dec_drop ##1 !dec_valid) else $error("decode pulse");
  cover property (dec_valid);
  cover property (dec_drop);
  cover property (gnss_valid && gnss_ready && gnss_last);
endmodule
bind napc_codec napc_codec_chk chk_u (.*);
`default_nettype wire

/* File: tb/napc_host_model.sv */
`timescale 1ns/100ps
`default_nettype none
module napc_host_model (
  // Clock and reset
  input  wire logic clk,
  input  wire logic sys_rst,
  // Stall control
  input  wire logic slow,
  // Sink handshakes
  output logic      tx_ready,
  output logic      gnss_ready
);
  int          seed = 32'hdbcd_06c5;
  logic [31:0] r;
  // ==========
  // Random backpressure
  // bytes taken in order
  always @(posedge clk or posedge sys_rst) begin
    r = $random(seed);
    if (sys_rst) begin
      tx_ready <= 1'b0;
      gnss_ready <= 1'b0;
    end else begin
      tx_ready <= !slow || r[0];
      gnss_ready <= !slow || r[1];
    end
  end
endmodule
`default_nettype wire

/* File: tb/napc_codec_bench.sv */
`timescale 1ns/100ps
`default_nettype none
module napc_codec_bench;
  import napc_pkg::*;
  logic         clk, sys_rst, rx_start, rx_valid, rx_last, tx_req, slow;
  logic         rx_ready, dec_valid, dec_drop, gnss_valid, gnss_ready, gnss_last;
  logic         tx_busy, tx_valid, tx_ready, tx_last;
  logic [7:0]   rx_id, rx_len, rx_data, tx_id, dec_id, gnss_data, tx_data, tx_len;
  logic [2:0]   dec_words;
  logic [191:0] dec_data;
  logic [159:0] tx_fields;
  logic [2047:0] pay;
  logic [203:0] de, dq[$];
  logic [16:0]  gq[$], tq[$];
  logic [7:0]   tid[11] = '{8'h2f, 8'h2f, 8'h30, 8'h34, 8'h35, 8'h2f, 8'h30, 8'h35, 8'h37, 8'h2e, 8'h30};
  logic [7:0]   tln[11] = '{8'h10, 8'h18, 8'h08, 8'h08, 8'h08, 8'h14, 8'h0c, 8'h04, 8'h00, 8'h08, 8'h08};
  logic [7:0]   xid[5] = '{8'h31, 8'h32, 8'h33, 8'h36, 8'h30};
  logic [7:0]   xln[5] = '{8'h08, 8'h0c, 8'h14, 8'h04, 8'h00};
  int           failures, checked, cyc, seed, i, k, n;

  napc_codec dut_u (.*);
  napc_host_model host_u (.*);

  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  // ==========
  // Compare and report
  task automatic cmp_dec(input logic [203:0] e, input logic [203:0] g);
    checked++;
    if (e !== g) begin
      failures++;
      $display("CHECK FAILED t=%0t exp=%h got=%h", $time, e, g);
    end
  endtask
  task automatic cmp_byte(input logic [16:0] e, input logic [16:0] g);
    checked++;
    if (e !== g) begin
      failures++;
      $display("CHECK FAILED t=%0t exp=%h got=%h", $time, e, g);
    end
  endtask
  task automatic tally_and_finish;
    $display("checked=%0d failures=%0d", checked, failures);
    if (failures == 0 && checked > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      failures++;
      tally_and_finish();
    end
    if (!sys_rst && (dec_valid || dec_drop)) begin
      de = dq.pop_front();
      cmp_dec(de, de[203] ? {dec_drop, 203'h0} : {dec_drop, dec_id, dec_words,
        dec_data & ({192{1'b1}} >> (192 - 32 * de[194:192]))});
    end
    if (!sys_rst && gnss_valid && gnss_ready)
      cmp_byte(gq.pop_front(), {gnss_last, 8'h00, gnss_data});
    if (!sys_rst && tx_valid && tx_ready)
      cmp_byte(tq.pop_front(), {tx_last, tx_len, tx_data});
  end

  // ==========
  // Drivers
  task automatic rnd;
    for (k = 0; k < 64; k++) pay[32*k+:32] = $random(seed);
  endtask
  task automatic rx_send(input logic [7:0] id, input logic [7:0] len, input int cnt);
    int j, t;
    @(posedge clk);
    rx_start <= 1'b1;
    rx_id <= id;
    rx_len <= len;
    @(posedge clk);
    rx_start <= 1'b0;
    for (j = 0; j < cnt; j++) begin
      rx_valid <= 1'b1;
      rx_data <= pay[8*j+:8];
      rx_last <= (j == cnt - 1);
      t = 0;
      do begin
        @(posedge clk);
        t++;
      end while (!rx_ready && t < 64);
      if (!rx_ready) j = cnt;
    end
    rx_valid <= 1'b0;
    rx_last <= 1'b0;
  endtask
  task automatic tx_send(input logic [7:0] id, input logic [7:0] len);
    int j;
    for (j = 0; j < len; j++) tq.push_back({j == len - 1, len, j > 16 ? 8'h00 : pay[8*j+:8]});
    @(posedge clk);
    tx_req <= 1'b1;
    tx_id <= id;
    tx_fields <= pay[159:0];
    repeat (2) @(posedge clk);
    tx_req <= 1'b0;
    j = 0;
    while ((tx_busy || tq.size() > 0) && j < 500) begin
      @(posedge clk);
      j++;
    end
  endtask

  // ==========
  // Main sequence
  initial begin
    seed = 32'hdbcd_06c5;
    {failures, checked, cyc} = '0;
    {rx_start, rx_valid, rx_last, tx_req, slow} = '0;
    {rx_id, rx_len, rx_data, tx_id, tx_fields} = '0;
    sys_rst = 1'b1;
    repeat (16) @(posedge clk);
    sys_rst <= 1'b0;
    for (i = 0; i < 11; i++) begin
      rnd();
      n = (i == 10) ? 4 : tln[i];
      if (i > 4)
        dq.push_back({1'b1, 203'h0});
      else
        dq.push_back({1'b0, tid[i], tln[i][4:2], pay[191:0] & ({192{1'b1}} >> (192 - 8 * tln[i]))});
      rx_send(tid[i], tln[i], n);
    end
    slow <= 1'b1;
    for (i = 0; i < 2; i++) begin
      rnd();
      n = i ? 3 : 255;
      for (k = 0; k < n; k++) gq.push_back({k == n - 1, 8'h00, pay[8*k+:8]});
      rx_send(ID_RTCM, n[7:0], n);
    end
    for (i = 0; i < 5; i++) begin
      slow <= i[0];
      rnd();
      tx_send(xid[i], xln[i]);
    end
    k = 0;
    while (dq.size() + gq.size() + tq.size() > 0 && k < 3000) begin
      @(posedge clk);
      k++;
    end
    if (k == 3000)
      failures++;
    tally_and_finish();
  end
endmodule
`default_nettype wire
